// File: core/rgbpi_top.sv
// Pixel input register and level encoder of a triple 8-bit video DAC.
// Assumes a controller drives all inputs synchronously to clk at the
// pixel rate, with composite sync already merged into one signal.
`include "rgbpi_defines.svh"
`default_nettype none

// Operation
// - Register all three colour words each edge
// - Register blank and sync on same edge
// - Encode blank by zeroing the data, sync as a weighted current
// - Sync pedestal on green output only
// - Levels: white, black, blank, sync per controls
// - Blank drives outputs to blanking level
// - Set bits steer weighted current to output
// - Distinct output step for every code
// - Pixel data ignored while blank low
// - Sync low removes forty IRE on green
module rgbpi_top #(
   parameter logic [`RGBPI_CUR_W-1:0] SYNC_WEIGHT = `RGBPI_SYNC_WEIGHT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`RGBPI_DATA_W-1:0] red_pixel_bits,
   input wire logic [`RGBPI_DATA_W-1:0] green_pixel_bits,
   input wire logic [`RGBPI_DATA_W-1:0] blue_pixel_bits,
   input wire logic blank_n,
   input wire logic sync_n,
   output logic [`RGBPI_CUR_W-1:0] red_current_output,
   output logic [`RGBPI_CUR_W-1:0] green_current_output,
   output logic [`RGBPI_CUR_W-1:0] blue_current_output,
   output logic [`RGBPI_DATA_W-1:0] red_bit_steer,
   output logic [`RGBPI_DATA_W-1:0] green_bit_steer,
   output logic [`RGBPI_DATA_W-1:0] blue_bit_steer,
   output rgbpi_pkg::rgbpi_level_t level_state
);

   // ************************************************************
   // Input register and level stage
   // ************************************************************
   rgbpi_pkg::rgbpi_top_state_t state;
   rgbpi_pkg::rgbpi_top_state_t next_state;

   always_comb begin
      next_state = state;
      // Colour words captured every edge
      next_state.cap_red = red_pixel_bits;
      next_state.cap_green = green_pixel_bits;
      next_state.cap_blue = blue_pixel_bits;
      // Controls on the very same edge as their pixel
      next_state.cap_blank_n = blank_n;
      next_state.cap_sync_n = sync_n;
      // Level decided from the captured set, one stage like the DACs
      next_state.level = rgbpi_pkg::rgbpi_classify(state.cap_red,
         state.cap_green, state.cap_blue, state.cap_blank_n,
         state.cap_sync_n);
      if (state.warm != `RGBPI_WARM_DONE) begin
         next_state.warm = state.warm + `RGBPI_WARM_W'(1);
      end
   end

   // Reset shows sync level: all currents zero, matching the level code
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= '{cap_red: `RGBPI_ZERO_CODE,
                    cap_green: `RGBPI_ZERO_CODE,
                    cap_blue: `RGBPI_ZERO_CODE,
                    cap_blank_n: 1'b0,
                    cap_sync_n: 1'b0,
                    level: rgbpi_pkg::RGBPI_LVL_SYNC,
                    warm: `RGBPI_WARM_W'(0)};
      end else begin
         state <= next_state;
      end
   end

   assign level_state = state.level;

   // ************************************************************
   // Converters
   // ************************************************************
   // Red and blue never carry the sync pedestal
   rgbpi_channel #(
      .ADD_SYNC(1'b0),
      .SYNC_WEIGHT(SYNC_WEIGHT)
   ) u_red (
      .clk(clk),
      .rstn(rstn),
      .pixel(state.cap_red),
      .blank_n(state.cap_blank_n),
      .sync_n(state.cap_sync_n),
      .bit_steer(red_bit_steer),
      .current(red_current_output)
   );

   rgbpi_channel #(
      .ADD_SYNC(1'b1),
      .SYNC_WEIGHT(SYNC_WEIGHT)
   ) u_green (
      .clk(clk),
      .rstn(rstn),
      .pixel(state.cap_green),
      .blank_n(state.cap_blank_n),
      .sync_n(state.cap_sync_n),
      .bit_steer(green_bit_steer),
      .current(green_current_output)
   );

   rgbpi_channel #(
      .ADD_SYNC(1'b0),
      .SYNC_WEIGHT(SYNC_WEIGHT)
   ) u_blue (
      .clk(clk),
      .rstn(rstn),
      .pixel(state.cap_blue),
      .blank_n(state.cap_blank_n),
      .sync_n(state.cap_sync_n),
      .bit_steer(blue_bit_steer),
      .current(blue_current_output)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   // Warm-up gate keeps $past from looking at pre-reset inputs
   logic warm_ok;
   assign warm_ok = (state.warm == `RGBPI_WARM_DONE);

   AST_CAPTURE_RED: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok && $past(blank_n, 2) |->
         red_current_output == {1'b0, $past(red_pixel_bits, 2)})
      else $error("Red output not the word from two edges earlier");

   AST_CAPTURE_BLUE: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok && $past(blank_n, 2) |->
         blue_current_output == {1'b0, $past(blue_pixel_bits, 2)})
      else $error("Blue output not the word from two edges earlier");

   AST_CONTROL_ALIGN: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok |-> level_state == rgbpi_pkg::rgbpi_classify(
         $past(red_pixel_bits, 2), $past(green_pixel_bits, 2),
         $past(blue_pixel_bits, 2), $past(blank_n, 2), $past(sync_n, 2)))
      else $error("Level code not aligned with its pixel");

   AST_BLANK_IGNORES_DATA: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok && !$past(blank_n, 2) |->
         red_current_output == `RGBPI_RESET_CUR &&
         blue_current_output == `RGBPI_RESET_CUR &&
         green_bit_steer == `RGBPI_ZERO_CODE)
      else $error("Pixel data leaked through while blanked");

   AST_BLANK_LEVEL: assert property (
      @(posedge clk) disable iff (!rstn)
      level_state == rgbpi_pkg::RGBPI_LVL_BLANK |->
         green_current_output == SYNC_WEIGHT &&
         red_current_output == `RGBPI_RESET_CUR)
      else $error("Blanking level wrong");

   AST_SYNC_LEVEL: assert property (
      @(posedge clk) disable iff (!rstn)
      level_state == rgbpi_pkg::RGBPI_LVL_SYNC |->
         green_current_output == `RGBPI_RESET_CUR &&
         red_current_output == `RGBPI_RESET_CUR &&
         blue_current_output == `RGBPI_RESET_CUR)
      else $error("Sync level not all zero");

   AST_WHITE_LEVEL: assert property (
      @(posedge clk) disable iff (!rstn)
      level_state == rgbpi_pkg::RGBPI_LVL_WHITE |->
         red_current_output == {1'b0, `RGBPI_FULL_CODE} &&
         green_current_output == {1'b0, `RGBPI_FULL_CODE} + SYNC_WEIGHT)
      else $error("White level wrong");

   AST_GREEN_PEDESTAL: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok |-> green_current_output ==
         rgbpi_pkg::rgbpi_bit_current(green_bit_steer) +
         ($past(sync_n, 2) ? SYNC_WEIGHT : `RGBPI_RESET_CUR))
      else $error("Green pedestal does not follow sync");

   AST_RB_NO_SYNC: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok && $past(blank_n, 2) && !$past(sync_n, 2) |->
         blue_current_output == {1'b0, $past(blue_pixel_bits, 2)} &&
         red_current_output == {1'b0, $past(red_pixel_bits, 2)})
      else $error("Sync disturbed red or blue");

   AST_DISTINCT_STEP: assert property (
      @(posedge clk) disable iff (!rstn)
      warm_ok && $past(blank_n, 2) && $past(blank_n, 3) &&
         $past(red_pixel_bits, 2) != $past(red_pixel_bits, 3) |->
         red_current_output != $past(red_current_output))
      else $error("Two codes gave the same red step");

   AST_ENCODE_WEIGHTS: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(level_state == rgbpi_pkg::RGBPI_LVL_NOSYNC) |->
         green_current_output == {1'b0, green_bit_steer})
      else $error("Sync-off video kept the pedestal");

endmodule

`default_nettype wire

// File: core/rgbpi_defines.svh
// Widths, reset values and level weights of the RGB pixel input stage.
// Assumes inclusion by bare name; definitions only.
`ifndef RGBPI_DEFINES_SVH
`define RGBPI_DEFINES_SVH

// ************************************************************
// Widths
// ************************************************************
`define RGBPI_DATA_W 8
`define RGBPI_CUR_W 9
`define RGBPI_WARM_W 2

// ************************************************************
// Codes and reset values
// ************************************************************
`define RGBPI_FULL_CODE 8'hff
`define RGBPI_ZERO_CODE 8'h00
`define RGBPI_RESET_CUR 9'h000
`define RGBPI_WARM_DONE 2'h3

// Sync pedestal in DAC LSB units (8.05 mA over 18.62 mA per 255 codes)
`define RGBPI_SYNC_WEIGHT 9'h06e

`endif

// File: core/rgbpi_pkg.sv
// Types and shared functions of the RGB pixel input stage.
// Assumes rgbpi_defines.svh is on the include path.
`include "rgbpi_defines.svh"
`default_nettype none

package rgbpi_pkg;

   // ************************************************************
   // Types
   // ************************************************************
   typedef logic [`RGBPI_DATA_W-1:0] rgbpi_word_t;
   typedef logic [`RGBPI_CUR_W-1:0] rgbpi_cur_t;

   typedef enum logic [5:0] {
      RGBPI_LVL_WHITE = 6'h01,
      RGBPI_LVL_VIDEO = 6'h02,
      RGBPI_LVL_BLACK = 6'h04,
      RGBPI_LVL_NOSYNC = 6'h08,
      RGBPI_LVL_BLANK = 6'h10,
      RGBPI_LVL_SYNC = 6'h20
   } rgbpi_level_t;

   typedef struct packed {
      rgbpi_word_t steer;
      rgbpi_cur_t current;
   } rgbpi_chan_state_t;

   typedef struct packed {
      rgbpi_word_t cap_red;
      rgbpi_word_t cap_green;
      rgbpi_word_t cap_blue;
      logic cap_blank_n;
      logic cap_sync_n;
      rgbpi_level_t level;
      logic [`RGBPI_WARM_W-1:0] warm;
   } rgbpi_top_state_t;

   // ************************************************************
   // Functions
   // ************************************************************
   // Each set bit steers its binary weighted current to the output
   function automatic rgbpi_cur_t rgbpi_bit_current(input rgbpi_word_t steer);
      rgbpi_cur_t sum;
      sum = '0;
      for (int i = 0; i < `RGBPI_DATA_W; i++) begin
         if (steer[i]) begin
            sum = sum + (rgbpi_cur_t'(1) << i);
         end
      end
      return sum;
   endfunction

   function automatic rgbpi_level_t rgbpi_classify(
      input rgbpi_word_t r,
      input rgbpi_word_t g,
      input rgbpi_word_t b,
      input logic blank_n,
      input logic sync_n
   );
      rgbpi_level_t lvl;
      lvl = RGBPI_LVL_VIDEO;
      if (!blank_n && !sync_n) begin
         lvl = RGBPI_LVL_SYNC;
      end else if (!blank_n) begin
         lvl = RGBPI_LVL_BLANK;
      end else if (!sync_n) begin
         lvl = RGBPI_LVL_NOSYNC;
      end else if (r == `RGBPI_FULL_CODE && g == `RGBPI_FULL_CODE &&
                   b == `RGBPI_FULL_CODE) begin
         lvl = RGBPI_LVL_WHITE;
      end else if (r == `RGBPI_ZERO_CODE && g == `RGBPI_ZERO_CODE &&
                   b == `RGBPI_ZERO_CODE) begin
         lvl = RGBPI_LVL_BLACK;
      end
      return lvl;
   endfunction

endpackage

`default_nettype wire

// File: core/rgbpi_channel.sv
// One colour channel: blank gating, bit steering and current encoding.
// Assumes inputs are already registered by the parent on the same clock.
`include "rgbpi_defines.svh"
`default_nettype none

module rgbpi_channel #(
   parameter logic ADD_SYNC = 1'b0,
   parameter logic [`RGBPI_CUR_W-1:0] SYNC_WEIGHT = `RGBPI_SYNC_WEIGHT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`RGBPI_DATA_W-1:0] pixel,
   input wire logic blank_n,
   input wire logic sync_n,
   output logic [`RGBPI_DATA_W-1:0] bit_steer,
   output logic [`RGBPI_CUR_W-1:0] current
);

   // ************************************************************
   // State
   // ************************************************************
   rgbpi_pkg::rgbpi_chan_state_t state;
   rgbpi_pkg::rgbpi_chan_state_t next_state;

   always_comb begin
      next_state = state;
      // Blank discards the pixel word entirely
      next_state.steer = blank_n ? pixel : `RGBPI_ZERO_CODE;
      // Weighted bit currents, plus the pedestal on green only
      next_state.current = rgbpi_pkg::rgbpi_bit_current(next_state.steer);
      if (ADD_SYNC && sync_n) begin
         // Sync low switches the pedestal off
         next_state.current = next_state.current + SYNC_WEIGHT;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= '{steer: `RGBPI_ZERO_CODE, current: `RGBPI_RESET_CUR};
      end else begin
         state <= next_state;
      end
   end

   assign bit_steer = state.steer;
   assign current = state.current;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_STEER_SUM: assert property (
      @(posedge clk) disable iff (!rstn)
      current[`RGBPI_DATA_W-1:0] ==
         ((ADD_SYNC && $past(sync_n)) ?
          bit_steer + SYNC_WEIGHT[`RGBPI_DATA_W-1:0] : bit_steer))
      else $error("Channel current does not match steered bits");

endmodule

`default_nettype wire

// File: bench/rgbpi_ctrl_model.sv
// Controller model: raster timing, random pixels, forced corner words.
// Assumes the bench drives force_en, force_val and sync_off at posedge.
`default_nettype none

module rgbpi_ctrl_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic force_en,
   input wire logic [25:0] force_val,
   input wire logic sync_off,
   output logic [7:0] red,
   output logic [7:0] green,
   output logic [7:0] blue,
   output logic blank_n,
   output logic sync_n
);
   timeunit 1ns;
   timeprecision 1ns;
   integer seed = 32'h1442;
   logic [3:0] col;
   logic [1:0] row;
   logic hs_n;
   logic vs_n;

   // *****************
   // Raster timing
   // *****************
   // Separate syncs merged into one composite sync
   assign hs_n = !(col == 4'hc || col == 4'hd);
   assign vs_n = !(row == 2'h3 && col >= 4'ha);

   // One pixel per clock; raster sync kept inside blanking, sync_n held low on every pixel while sync_off and force_en is low
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         col <= 4'h0;
         row <= 2'h0;
         {red, green, blue, blank_n, sync_n} <= 26'h000_0000;
      end else begin
         col <= col + 4'h1;
         if (col == 4'hf) begin
            row <= row + 2'h1;
         end
         if (force_en) begin
            {red, green, blue, blank_n, sync_n} <= force_val;
         end else begin
            // Pixel data stays random while blanked to expose leakage
            red <= 8'($random(seed));
            green <= 8'($random(seed));
            blue <= 8'($random(seed));
            blank_n <= col < 4'ha;
            // Sync held low when not wanted
            sync_n <= sync_off ? 1'b0 : (hs_n & vs_n);
         end
      end
   end
endmodule

`default_nettype wire

// File: bench/rgbpi_top_tb.sv
// Testbench of the RGB pixel input stage against a controller model.
// Assumes rgbpi_defines.svh on the include path and rgbpi_pkg compiled.
`include "rgbpi_defines.svh"
`default_nettype none

module rgbpi_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0] SW = `RGBPI_SYNC_WEIGHT;
   localparam logic [25:0] CORNER [6] = '{
      {24'hff_ffff, 2'b11}, {24'h00_0000, 2'b11}, {24'hff_ffff, 2'b01},
      {24'hff_ffff, 2'b00}, {24'h80_4001, 2'b10}, {24'h01_0280, 2'b11}};
   logic clk, rstn, force_en, sync_off, bn, sn;
   logic [25:0] force_val, s1, s2;
   logic [7:0] r, g, b, sr, sg, sb;
   logic [8:0] cr, cg, cb;
   rgbpi_pkg::rgbpi_level_t lvl;
   int n_after;
   int error_cnt = 0;
   int tests_run = 0;

   rgbpi_top #(.SYNC_WEIGHT(SW)) u_rgbpi_top (.clk(clk), .rstn(rstn),
      .red_pixel_bits(r), .green_pixel_bits(g), .blue_pixel_bits(b),
      .blank_n(bn), .sync_n(sn), .red_current_output(cr),
      .green_current_output(cg), .blue_current_output(cb),
      .red_bit_steer(sr), .green_bit_steer(sg), .blue_bit_steer(sb),
      .level_state(lvl));

   rgbpi_ctrl_model u_rgbpi_ctrl_model (.clk(clk), .rstn(rstn),
      .force_en(force_en), .force_val(force_val), .sync_off(sync_off),
      .red(r), .green(g), .blue(b), .blank_n(bn), .sync_n(sn));

   // *****************
   // Expectations
   // *****************
   function automatic logic [5:0] exp_lvl(input logic [25:0] v);
      if (!v[1]) return v[0] ? 6'h10 : 6'h20;
      if (!v[0]) return 6'h08;
      if (v[25:2] == 24'hff_ffff) return 6'h01;
      if (v[25:2] == 24'h00_0000) return 6'h04;
      return 6'h02;
   endfunction

   function automatic logic [8:0] exp_cur(input logic [7:0] d,
         input logic [25:0] v, input logic grn);
      logic [8:0] c;
      c = v[1] ? {1'b0, d} : 9'h000;
      if (grn && v[0]) c = c + SW;
      return c;
   endfunction

   function automatic logic [7:0] exp_st(input logic [7:0] d,
         input logic [25:0] v);
      return v[1] ? d : 8'h00;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // *****************
   // Monitor
   // *****************
   // Mirror of the two-edge latency: s2 is what the outputs now reflect
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n_after <= 0;
      end else begin
         s1 <= {r, g, b, bn, sn};
         s2 <= s1;
         if (n_after < 2) n_after <= n_after + 1;
      end
   end

   always @(negedge clk) begin
      if (!rstn) begin
         check({7'h00, cg}, {7'h00, cr | cb});
         check({10'h000, lvl}, 16'h0020);
      end else if (n_after >= 2) begin
         check({7'h00, cr}, {7'h00, exp_cur(s2[25:18], s2, 1'b0)});
         check({7'h00, cg}, {7'h00, exp_cur(s2[17:10], s2, 1'b1)});
         check({7'h00, cb}, {7'h00, exp_cur(s2[9:2], s2, 1'b0)});
         check({sr, sg}, {exp_st(s2[25:18], s2), exp_st(s2[17:10], s2)});
         check({8'h00, sb}, {8'h00, exp_st(s2[9:2], s2)});
         check({10'h000, lvl}, {10'h000, exp_lvl(s2)});
      end
   end

   // *****************
   // Stimulus
   // *****************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rstn = 1'b0;
      force_en = 1'b0;
      force_val = 26'h000_0000;
      sync_off = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (200) @(posedge clk);
      // Corner words back to back, each held for a few pixels
      foreach (CORNER[i]) begin
         force_en <= 1'b1;
         force_val <= CORNER[i];
         repeat (3) @(posedge clk);
      end
      force_en <= 1'b0;
      sync_off <= 1'b1;
      repeat (64) @(posedge clk);
      sync_off <= 1'b0;
      // Second reset in mid-line
      #13 rstn = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (100) @(posedge clk);
      end_of_test();
   end

   // Run needs about 400 cycles; the limit leaves ample margin
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
endmodule

`default_nettype wire
